// [src/ris_pkg.sv]
// Package with the register map, reset values and field positions of the reference selector.
package ris_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [6:0] OFF_SWING    = 7'h13;
    localparam logic [6:0] OFF_PRIO     = 7'h14;
    localparam logic [6:0] OFF_CTRL     = 7'h15;
    localparam logic [6:0] OFF_HOLDOFF  = 7'h16;
    localparam logic [6:0] OFF_COUNTER  = 7'h17;
    localparam logic [6:0] OFF_COMMIT   = 7'h18;
    localparam logic [6:0] OFF_STATUS   = 7'h19;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_PRIO     = 8'hE0;
    localparam logic [7:0] RST_CTRL     = 8'h00;
    localparam logic [7:0] RST_HOLDOFF  = 8'h80;
    localparam logic [7:0] RST_COUNTER  = 8'h82;
    localparam logic [1:0] RST_SWING    = 2'h0;

    // ************************************************************
    // Field positions and masks
    // ************************************************************
    localparam int CTRL_LOCK_BLOCK      = 6;
    localparam int CTRL_PRESCALE        = 5;
    localparam int CTRL_REVERTIVE_SWITCH_EN            = 4;
    localparam int CTRL_MODE_LSB        = 2;
    localparam int CTRL_SEL_LSB         = 0;
    localparam logic [7:0] MASK_CTRL    = 8'h7F;
    localparam logic [7:0] MASK_COUNTER = 8'hCF;

    // ************************************************************
    // Serial frame layout
    // ************************************************************
    localparam logic [4:0] SPI_ADDR_DONE = 5'h07;
    localparam logic [4:0] SPI_LAST_BIT  = 5'h0F;

    // ************************************************************
    // Output swing levels
    // ************************************************************
    typedef enum logic [1:0] {
        RIS_SWING_250MV,
        RIS_SWING_500MV,
        RIS_SWING_750MV
    } ris_swing_t;

    localparam ris_swing_t SWING_STARTUP = RIS_SWING_750MV;

endpackage

// [src/ris_reference_selector.sv]
// Reference input selector with its serial configuration registers and output swing control.
// Overview of operation
// - Two-bit priorities; input0 resets 11, input1 10.
// - Equal priorities resolve by ascending input index.
// - Prescale bit: zero divides one, one four.
// - Revertive enable ignored in manual modes.
// - Revertive off: revalidation keeps current selection.
// - Revertive on: switch only to higher-ranked input.
// - Swing code maps 250, 500, 500, 750 mV.
// - Startup drives 750 mV, field reads 00.
// - Swing applies only after commit register write.
// - Priority map at input_priority_map, control at selection_control.
// - Mode: manual, auto, short holdover, auto holdover.
// - Manual modes select input by select field.
`timescale 1ns/1ps
module ris_reference_selector (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       spi_sclk_in,
    input  wire logic       spi_cs_n_in,
    input  wire logic       spi_sdi_in,
    output logic            spi_sdo_out,
    output logic            spi_sdo_oe_out,
    input  wire logic [3:0] los_in,
    output logic [1:0]      ref_sel_out,
    output logic [1:0]      swing_level_out,
    output logic            validation_prescale_out,
    output logic            lock_block_out,
    output logic [7:0]      holdoff_count_out,
    output logic [7:0]      counter_setup_out
);

    // ************************************************************
    // Helper functions
    // ************************************************************
    function automatic logic [1:0] prio_of(input logic [7:0] map, input logic [1:0] idx);
        prio_of = map[7 - 2 * idx -: 2];
    endfunction

    function automatic logic outranks(input logic [7:0] m, input logic [1:0] a, b);
        outranks = prio_of(m, a) > prio_of(m, b) || (prio_of(m, a) == prio_of(m, b) && a < b);
    endfunction

    // Returns {found, index} of the best available input.
    function automatic logic [2:0] best_of(input logic [7:0] map, input logic [3:0] avail);
        logic       found;
        logic [1:0] idx;
        found = 1'b0;
        idx   = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (avail[i] && (!found || outranks(map, i[1:0], idx))) begin
                found = 1'b1;
                idx   = i[1:0];
            end
        end
        best_of = {found, idx};
    endfunction

    function automatic logic [1:0] swing_of(input logic [1:0] code);
        unique case (code)
            2'h0:    swing_of = ris_pkg::RIS_SWING_250MV;
            2'h3:    swing_of = ris_pkg::RIS_SWING_750MV;
            default: swing_of = ris_pkg::RIS_SWING_500MV;
        endcase
    endfunction

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic       sclk_s1, sclk_s2, sclk_d;
    logic       cs_n_s1, cs_n_s2;
    logic       sdi_s1, sdi_s2;
    logic [3:0] los_s1, los_s2, los_d;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            {sclk_s1, sclk_s2, sclk_d} <= 3'h0;
            {cs_n_s1, cs_n_s2}         <= 2'h3;
            {sdi_s1, sdi_s2}           <= 2'h0;
            los_s1                     <= 4'hF;
            los_s2                     <= 4'hF;
            los_d                      <= 4'hF;
        end else begin
            {sclk_s1, sclk_s2, sclk_d} <= {spi_sclk_in, sclk_s1, sclk_s2};
            {cs_n_s1, cs_n_s2}         <= {spi_cs_n_in, cs_n_s1};
            {sdi_s1, sdi_s2}           <= {spi_sdi_in, sdi_s1};
            los_s1                     <= los_in;
            los_s2                     <= los_s1;
            los_d                      <= los_s2;
        end
    end

    // ************************************************************
    // Serial configuration port
    // ************************************************************
    // A frame is sixteen bits, MSB first: read flag, seven address bits, eight data bits.
    logic        sclk_rise, sclk_fall;
    logic [4:0]  bit_cnt;
    logic [15:0] shift_in;
    logic [7:0]  rd_shift;
    logic        wr_en;
    logic [6:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;

    assign sclk_rise = sclk_s2 & ~sclk_d;
    assign sclk_fall = ~sclk_s2 & sclk_d;
    assign wr_en     = sclk_rise && !cs_n_s2 && bit_cnt == ris_pkg::SPI_LAST_BIT && !shift_in[14];
    assign wr_addr   = shift_in[13:7];
    assign wr_data   = {shift_in[6:0], sdi_s2};

    always_ff @(posedge mclk_in) begin
        if (rst_in || cs_n_s2) begin
            bit_cnt  <= 5'h00;
            shift_in <= 16'h0000;
        end else if (sclk_rise) begin
            bit_cnt  <= bit_cnt + 5'h01;
            shift_in <= {shift_in[14:0], sdi_s2};
        end
    end

    // Read data changes on the falling edge so the master samples it stable on the rising one.
    always_ff @(posedge mclk_in) begin
        if (rst_in || cs_n_s2) begin
            rd_shift       <= 8'h00;
            spi_sdo_out    <= 1'b0;
            spi_sdo_oe_out <= 1'b0;
        end else if (sclk_rise && bit_cnt == ris_pkg::SPI_ADDR_DONE && shift_in[6]) begin
            rd_shift       <= rd_data;
            spi_sdo_oe_out <= 1'b1;
        end else if (sclk_fall && spi_sdo_oe_out && bit_cnt > ris_pkg::SPI_ADDR_DONE) begin
            spi_sdo_out <= rd_shift[7];
            rd_shift    <= {rd_shift[6:0], 1'b0};
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic [7:0] input_priority_map;
    logic [7:0] selection_control;
    logic [7:0] holdoff_period;
    logic [7:0] counter_setup;
    logic [1:0] vcxo_out_swing;
    logic       commit_pulse;
    logic [1:0] selection_mode;
    logic [1:0] manual_sel;
    logic       revertive_switch_en;
    logic [6:0] rd_addr;

    assign selection_mode      = selection_control[ris_pkg::CTRL_MODE_LSB +: 2];
    assign manual_sel          = selection_control[ris_pkg::CTRL_SEL_LSB +: 2];
    assign revertive_switch_en = selection_control[ris_pkg::CTRL_REVERTIVE_SWITCH_EN];
    assign commit_pulse        = wr_en && wr_addr == ris_pkg::OFF_COMMIT;
    assign rd_addr             = {shift_in[5:0], sdi_s2};

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            input_priority_map <= ris_pkg::RST_PRIO;
            selection_control  <= ris_pkg::RST_CTRL;
            holdoff_period     <= ris_pkg::RST_HOLDOFF;
            counter_setup      <= ris_pkg::RST_COUNTER;
            vcxo_out_swing     <= ris_pkg::RST_SWING;
        end else if (wr_en) begin
            unique case (wr_addr)
                ris_pkg::OFF_PRIO:    input_priority_map <= wr_data;
                ris_pkg::OFF_CTRL:    selection_control  <= wr_data & ris_pkg::MASK_CTRL;
                ris_pkg::OFF_HOLDOFF: holdoff_period     <= wr_data;
                ris_pkg::OFF_COUNTER: counter_setup      <= wr_data & ris_pkg::MASK_COUNTER;
                ris_pkg::OFF_SWING:   vcxo_out_swing     <= wr_data[1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (rd_addr)
            ris_pkg::OFF_PRIO:    rd_data = input_priority_map;
            ris_pkg::OFF_CTRL:    rd_data = selection_control;
            ris_pkg::OFF_HOLDOFF: rd_data = holdoff_period;
            ris_pkg::OFF_COUNTER: rd_data = counter_setup;
            ris_pkg::OFF_SWING:   rd_data = {6'h00, vcxo_out_swing};
            ris_pkg::OFF_STATUS:  rd_data = {2'h0, los_s2, ref_sel_out};
            default:              rd_data = 8'h00;
        endcase
    end

    // ************************************************************
    // Output swing
    // ************************************************************
    // The pad level follows the field only on commit, so software can stage it safely.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            swing_level_out <= ris_pkg::SWING_STARTUP;
        end else if (commit_pulse) begin
            swing_level_out <= swing_of(vcxo_out_swing);
        end
    end

    // ************************************************************
    // Static control outputs
    // ************************************************************
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            validation_prescale_out <= 1'b0;
            lock_block_out          <= 1'b0;
            holdoff_count_out       <= ris_pkg::RST_HOLDOFF;
            counter_setup_out       <= ris_pkg::RST_COUNTER;
        end else begin
            validation_prescale_out <= selection_control[ris_pkg::CTRL_PRESCALE];
            lock_block_out          <= selection_control[ris_pkg::CTRL_LOCK_BLOCK];
            holdoff_count_out       <= holdoff_period;
            counter_setup_out       <= counter_setup;
        end
    end

    // ************************************************************
    // Reference selection
    // ************************************************************
    logic [2:0] best;
    logic [3:0] reval;
    logic       reval_up;
    logic       cur_lost;
    logic       auto_mode;

    assign best      = best_of(input_priority_map, ~los_s2);
    assign reval     = los_d & ~los_s2;
    assign cur_lost  = los_s2[ref_sel_out];
    assign auto_mode = selection_mode[0];

    always_comb begin
        reval_up = 1'b0;
        for (int i = 0; i < 4; i++) begin
            reval_up = reval_up | (reval[i] & outranks(input_priority_map, i[1:0], ref_sel_out));
        end
    end

    // A revertive move needs a revalidated input that outranks the one in use.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ref_sel_out <= 2'h0;
        end else if (!auto_mode) begin
            ref_sel_out <= manual_sel;
        end else if (cur_lost && best[2]) begin
            ref_sel_out <= best[1:0];
        end else if (revertive_switch_en && reval_up && best[2]) begin
            ref_sel_out <= best[1:0];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_prio_reset: assert property (@(posedge mclk_in)
        $fell(rst_in) |-> input_priority_map == 8'hE0 && ref_sel_out == 2'h0)
        else $error("Priority map or selection wrong after reset.");

    a_auto_pick: assert property (@(posedge mclk_in) disable iff (rst_in)
        $past(auto_mode) && $changed(ref_sel_out) |-> ref_sel_out == $past(best[1:0]))
        else $error("Automatic switch did not take the best input.");

    a_prescale_follow: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_en && wr_addr == 7'h15 |-> ##2 validation_prescale_out == $past(wr_data[5], 2))
        else $error("Prescale output did not follow the control write.");

    a_manual_sel: assert property (@(posedge mclk_in) disable iff (rst_in)
        !selection_control[2] ##1 !selection_control[2] |-> ref_sel_out == $past(manual_sel))
        else $error("Manual mode did not follow the select field.");

    a_no_revert: assert property (@(posedge mclk_in) disable iff (rst_in)
        auto_mode && !revertive_switch_en && !cur_lost |=> $stable(ref_sel_out))
        else $error("Selection changed with revertive switching off.");

    a_revert_up: assert property (@(posedge mclk_in) disable iff (rst_in)
        auto_mode && revertive_switch_en && reval_up |=> ref_sel_out == $past(best[1:0]))
        else $error("Revertive switch did not take the higher input.");

    a_revert_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
        auto_mode && revertive_switch_en && !cur_lost && !reval_up |=> $stable(ref_sel_out))
        else $error("Revertive switch taken without an outranking input.");

    a_swing_startup: assert property (@(posedge mclk_in)
        $fell(rst_in) |-> swing_level_out == 2'h2 && vcxo_out_swing == 2'h0)
        else $error("Startup swing is not the top level.");

    a_swing_commit: assert property (@(posedge mclk_in) disable iff (rst_in)
        $changed(swing_level_out) |-> $past(commit_pulse))
        else $error("Swing level changed without a commit write.");

    a_swing_map: assert property (@(posedge mclk_in) disable iff (rst_in)
        commit_pulse && vcxo_out_swing == 2'h2 |=> swing_level_out == 2'h1)
        else $error("Swing code 10 did not give the middle level.");

    a_loss_move: assert property (@(posedge mclk_in) disable iff (rst_in)
        auto_mode && cur_lost && best[2] |=> ref_sel_out == $past(best[1:0]))
        else $error("Lost reference was not replaced.");

endmodule // ris_reference_selector

// [verification/ris_host_model.sv]
// Host model that drives the serial configuration port in mode 0.
`timescale 1ns/1ps
module ris_host_model (
    input  wire logic mclk_in,
    input  wire logic spi_sdo_in,
    output logic      spi_sclk_out,
    output logic      spi_cs_n_out,
    output logic      spi_sdi_out
);
    initial begin
        spi_sclk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_sdi_out  = 1'b0;
    end

    // Five cycles per phase leaves margin over the three the synchroniser needs.
    task automatic half();
        repeat (5) @(negedge mclk_in);
    endtask

    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {rd, addr, wdata};
        rdata = 8'h00;
        @(negedge mclk_in);
        spi_cs_n_out = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_sdi_out = frame[i];
            half();
            if (i < 8) rdata = {rdata[6:0], spi_sdo_in};
            spi_sclk_out = 1'b1;
            half();
            spi_sclk_out = 1'b0;
        end
        half();
        spi_cs_n_out = 1'b1;
        // A released line flips, so a stale level is never mistaken for data.
        spi_sdi_out = ~spi_sdi_out;
        repeat (6) @(negedge mclk_in);
    endtask
endmodule // ris_host_model

// [verification/ris_reference_selector_test.sv]
// Self-checking testbench of the reference selector.
`timescale 1ns/1ps
module ris_reference_selector_test;
    logic       mclk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       sclk, cs_n, sdi, sdo, sdo_oe, pre, lb;
    logic [3:0] los_in = 4'h0;
    logic [1:0] ref_sel, swing;
    logic [7:0] rd, hold_cnt, cnt_setup;
    int         err_count = 0;
    int         check_count = 0;

    always #2.5 mclk_in = ~mclk_in;

    ris_reference_selector i_dut (
        .mclk_in(mclk_in), .rst_in(rst_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
        .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe), .los_in(los_in),
        .ref_sel_out(ref_sel), .swing_level_out(swing), .validation_prescale_out(pre),
        .lock_block_out(lb), .holdoff_count_out(hold_cnt), .counter_setup_out(cnt_setup)
    );

    ris_host_model i_host (
        .mclk_in(mclk_in), .spi_sdo_in(sdo_oe ? sdo : ~sdo), .spi_sclk_out(sclk),
        .spi_cs_n_out(cs_n), .spi_sdi_out(sdi)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_host.xfer(1'b0, a, d, rd);
    endtask

    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        i_host.xfer(1'b1, a, 8'h00, rd);
        check(rd, exp);
    endtask

    // Waits a bounded time for the selection; a miss ends the run.
    task automatic wait_sel(input logic [1:0] exp);
        for (int n = 0; n < 20 && ref_sel !== exp; n++) @(negedge mclk_in);
        check({6'h00, ref_sel}, {6'h00, exp});
        if (ref_sel !== exp) finish_test();
    endtask

    task automatic hold_sel(input logic [1:0] exp);
        repeat (20) @(negedge mclk_in);
        check({6'h00, ref_sel}, {6'h00, exp});
    endtask

    task automatic set_los(input logic [3:0] v);
        @(negedge mclk_in);
        los_in = v;
        repeat (5) @(negedge mclk_in);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rdchk(ris_pkg::OFF_PRIO, 8'hE0);
        rdchk(ris_pkg::OFF_CTRL, 8'h00);
        check({6'h00, swing}, 8'h02);
        rdchk(ris_pkg::OFF_SWING, 8'h00);
        rdchk(7'h7F, 8'h00);
        check({7'h00, lb}, 8'h00);
        check(hold_cnt, ris_pkg::RST_HOLDOFF);
        check(cnt_setup, ris_pkg::RST_COUNTER);
        wr(ris_pkg::OFF_COUNTER, 8'hFF);
        check(cnt_setup, 8'hCF);
        rdchk(ris_pkg::OFF_COUNTER, 8'hCF);
        wr(ris_pkg::OFF_HOLDOFF, 8'h3C);
        check(hold_cnt, 8'h3C);
        rdchk(ris_pkg::OFF_HOLDOFF, 8'h3C);
    endtask

    task automatic t_swing();
        logic [1:0] lvl [4];
        logic [1:0] prev;
        lvl = '{2'h0, 2'h1, 2'h1, 2'h2};
        prev = 2'h2;
        for (int c = 0; c < 4; c++) begin
            wr(ris_pkg::OFF_SWING, 8'(c));
            check({6'h00, swing}, {6'h00, prev});
            wr(ris_pkg::OFF_COMMIT, 8'h00);
            check({6'h00, swing}, {6'h00, lvl[c]});
            prev = lvl[c];
        end
    endtask

    task automatic t_prescale();
        wr(ris_pkg::OFF_CTRL, 8'hE0);
        check({7'h00, pre}, 8'h01);
        check({7'h00, lb}, 8'h01);
        rdchk(ris_pkg::OFF_CTRL, 8'h60);
        wr(ris_pkg::OFF_CTRL, 8'h00);
        check({7'h00, pre}, 8'h00);
        check({7'h00, lb}, 8'h00);
    endtask

    task automatic t_manual();
        wr(ris_pkg::OFF_CTRL, 8'h01);
        wait_sel(2'h1);
        wr(ris_pkg::OFF_CTRL, 8'h1A);
        wait_sel(2'h2);
        set_los(4'h2);
        set_los(4'h0);
        hold_sel(2'h2);
    endtask

    // Equal priorities first, so the picks under map 55 rest on index order alone.
    task automatic t_auto();
        wr(ris_pkg::OFF_PRIO, 8'h55);
        wr(ris_pkg::OFF_CTRL, 8'h04);
        hold_sel(2'h2);
        set_los(4'h4);
        wait_sel(2'h0);
        set_los(4'h5);
        wait_sel(2'h1);
        set_los(4'h4);
        hold_sel(2'h1);
        wr(ris_pkg::OFF_CTRL, 8'h14);
        set_los(4'h0);
        hold_sel(2'h1);
        set_los(4'h1);
        set_los(4'h0);
        wait_sel(2'h0);
        wr(ris_pkg::OFF_PRIO, 8'hD5);
        set_los(4'h4);
        set_los(4'h0);
        hold_sel(2'h0);
        wr(ris_pkg::OFF_CTRL, 8'h1C);
        set_los(4'h1);
        wait_sel(2'h1);
    endtask

    initial begin
        repeat (5) @(negedge mclk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        t_reset();
        t_swing();
        t_prescale();
        t_manual();
        t_auto();
        finish_test();
    end
endmodule // ris_reference_selector_test
